// *** design/spu_defines.svh ***
// constants for the stack pointer update block
`ifndef SPU_DEFINES_SVH
`define SPU_DEFINES_SVH
`define SPU_ADDR_W       32
`define SPU_NUM_AREGS    8
`define SPU_SP_INDEX     3'h7
`define SPU_SIZE_BYTE    3'h1
`define SPU_SIZE_WORD    3'h2
`define SPU_SIZE_LONG    3'h4
`define SPU_SP_BYTE_STEP 3'h2
`define SPU_RESET_ADDR   32'h0000_0000
`endif

// *** design/spu_pkg.sv ***
// types for the stack pointer update block
package spu_pkg;
    typedef enum logic [1:0] {
        SPU_SZ_BYTE = 2'h0,
        SPU_SZ_WORD = 2'h1,
        SPU_SZ_LONG = 2'h2
    } spu_size_e;
    typedef enum logic [1:0] {
        SPU_MODE_PLAIN   = 2'h0,
        SPU_MODE_PREDEC  = 2'h1,
        SPU_MODE_POSTINC = 2'h2
    } spu_mode_e;
    typedef enum logic [1:0] {
        SPU_SEL_USER      = 2'h0,
        SPU_SEL_INTERRUPT = 2'h1,
        SPU_SEL_MASTER    = 2'h2
    } spu_sel_e;
endpackage

// *** design/spu_step_calc.sv ***
// step size of an automatic address register update
`timescale 1ns/1ps
`default_nettype none
`include "spu_defines.svh"
module spu_step_calc
(
    input  wire logic [2:0]          i_reg_num,
    input  wire spu_pkg::spu_size_e  i_size,
    output logic      [2:0]          o_step
);
    always_comb
    begin
        unique case (i_size)
            spu_pkg::SPU_SZ_BYTE:
            begin
                // stack stays word aligned for byte items
                if (i_reg_num == `SPU_SP_INDEX)
                    o_step = `SPU_SP_BYTE_STEP;
                else
                    o_step = `SPU_SIZE_BYTE;
            end
            spu_pkg::SPU_SZ_WORD: o_step = `SPU_SIZE_WORD;
            spu_pkg::SPU_SZ_LONG: o_step = `SPU_SIZE_LONG;
            default:              o_step = `SPU_SIZE_LONG;
        endcase
    end
endmodule // spu_step_calc
`default_nettype wire

// *** design/spu_stack_pointer_update.sv ***
// address register file with stack pointer banking and auto update
`timescale 1ns/1ps
`default_nettype none
`include "spu_defines.svh"
// Functional notes
// - Register seven is the system stack pointer for all stack access.
// - One of user, interrupt, master pointers is active and shown as seven.
// - Byte items through the stack pointer move it by two.
// - Predecrement lowers the register first and uses the new value.
// - Postincrement uses the old value and raises the register after.
// - A down-growing stack leaves the register at the top item.
// - An up-growing stack leaves the register at the next free slot.
module spu_stack_pointer_update
#(
    parameter int ADDR_W = `SPU_ADDR_W
)
(
    input  wire logic               i_clk_sys,
    input  wire logic               i_reset_n,
    input  wire spu_pkg::spu_sel_e  i_sp_select,
    input  wire logic               i_access,
    input  wire logic               i_stack_access,
    input  wire logic [2:0]         i_reg_num,
    input  wire spu_pkg::spu_mode_e i_mode,
    input  wire spu_pkg::spu_size_e i_size,
    input  wire logic               i_write,
    input  wire logic [2:0]         i_write_num,
    input  wire logic [ADDR_W-1:0]  i_write_data,
    input  wire logic [2:0]         i_read_num,
    output logic      [ADDR_W-1:0]  o_read_data,
    output logic      [ADDR_W-1:0]  o_mem_addr,
    output logic                    o_mem_valid,
    output logic      [ADDR_W-1:0]  o_system_stack_pointer_reg,
    output logic      [ADDR_W-1:0]  o_user_stack_pointer,
    output logic      [ADDR_W-1:0]  o_interrupt_stack_pointer,
    output logic      [ADDR_W-1:0]  o_master_stack_pointer
);
    ////////////////////////////////////////////////////////////////////
    // registers: a0..a6 plus three banked stack pointers
    logic [ADDR_W-1:0] areg_reg  [0:6];
    logic [ADDR_W-1:0] areg_next [0:6];
    logic [ADDR_W-1:0] usp_reg, usp_next;
    logic [ADDR_W-1:0] isp_reg, isp_next;
    logic [ADDR_W-1:0] msp_reg, msp_next;
    logic [ADDR_W-1:0] mem_addr_reg, mem_addr_next;
    logic              mem_valid_reg, mem_valid_next;
    logic [2:0]        step;
    logic [2:0]        acc_num;
    logic [ADDR_W-1:0] active_sp;
    logic [ADDR_W-1:0] cur_val;
    logic [ADDR_W-1:0] new_val;
    logic              upd;

    spu_step_calc spu_step_calc_i
    (
        .i_reg_num (acc_num),
        .i_size    (i_size),
        .o_step    (step)
    );

    ////////////////////////////////////////////////////////////////////
    // active pointer selection
    always_comb
    begin
        unique case (i_sp_select)
            spu_pkg::SPU_SEL_INTERRUPT: active_sp = isp_reg;
            spu_pkg::SPU_SEL_MASTER:    active_sp = msp_reg;
            default:                    active_sp = usp_reg;
        endcase
    end

    // implicit stack accesses always go through register seven
    assign acc_num = i_stack_access ? `SPU_SP_INDEX : i_reg_num;
    assign cur_val = (acc_num == `SPU_SP_INDEX) ? active_sp
                                                : areg_reg[acc_num];

    ////////////////////////////////////////////////////////////////////
    // address computation and update
    always_comb
    begin
        new_val        = cur_val;
        upd            = 1'b0;
        mem_valid_next = i_access;
        mem_addr_next  = cur_val;
        if (i_access)
        begin
            unique case (i_mode)
                spu_pkg::SPU_MODE_PREDEC:
                begin
                    // decrement first, access at new value
                    new_val       = cur_val - ADDR_W'(step);
                    mem_addr_next = new_val;
                    upd           = 1'b1;
                end
                spu_pkg::SPU_MODE_POSTINC:
                begin
                    // access at old value, then increment
                    new_val       = cur_val + ADDR_W'(step);
                    mem_addr_next = cur_val;
                    upd           = 1'b1;
                end
                default:
                begin
                    mem_addr_next = cur_val;
                end
            endcase
        end
    end

    // a direct write loses to an auto update of the same register in
    // the same cycle; decode must not issue both together
    always_comb
    begin
        for (int k = 0; k < 7; k++)
            areg_next[k] = areg_reg[k];
        usp_next = usp_reg;
        isp_next = isp_reg;
        msp_next = msp_reg;
        if (i_write)
        begin
            if (i_write_num == `SPU_SP_INDEX)
            begin
                unique case (i_sp_select)
                    spu_pkg::SPU_SEL_INTERRUPT: isp_next = i_write_data;
                    spu_pkg::SPU_SEL_MASTER:    msp_next = i_write_data;
                    default:                    usp_next = i_write_data;
                endcase
            end
            else
                areg_next[i_write_num] = i_write_data;
        end
        if (upd)
        begin
            if (acc_num == `SPU_SP_INDEX)
            begin
                unique case (i_sp_select)
                    spu_pkg::SPU_SEL_INTERRUPT: isp_next = new_val;
                    spu_pkg::SPU_SEL_MASTER:    msp_next = new_val;
                    default:                    usp_next = new_val;
                endcase
            end
            else
                areg_next[acc_num] = new_val;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // storage
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            for (int k = 0; k < 7; k++)
                areg_reg[k] <= `SPU_RESET_ADDR;
            usp_reg       <= `SPU_RESET_ADDR;
            isp_reg       <= `SPU_RESET_ADDR;
            msp_reg       <= `SPU_RESET_ADDR;
            mem_addr_reg  <= `SPU_RESET_ADDR;
            mem_valid_reg <= 1'b0;
        end
        else
        begin
            for (int k = 0; k < 7; k++)
                areg_reg[k] <= areg_next[k];
            usp_reg       <= usp_next;
            isp_reg       <= isp_next;
            msp_reg       <= msp_next;
            mem_addr_reg  <= mem_addr_next;
            mem_valid_reg <= mem_valid_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign o_mem_addr                 = mem_addr_reg;
    assign o_mem_valid                = mem_valid_reg;
    assign o_system_stack_pointer_reg = active_sp;
    assign o_user_stack_pointer       = usp_reg;
    assign o_interrupt_stack_pointer  = isp_reg;
    assign o_master_stack_pointer     = msp_reg;
    assign o_read_data = (i_read_num == `SPU_SP_INDEX) ? active_sp
                                                       : areg_reg[i_read_num];

    ////////////////////////////////////////////////////////////////////
    // checks
    logic [2:0] sp_byte_step;
    assign sp_byte_step = `SPU_SP_BYTE_STEP;

    // byte access through seven, implicit or named explicitly
    sequence s_sp_byte_acc;
        i_access && (i_stack_access || i_reg_num == `SPU_SP_INDEX)
            && i_size == spu_pkg::SPU_SZ_BYTE
            && i_mode != spu_pkg::SPU_MODE_PLAIN && !i_write;
    endsequence

    a_sp_byte_two: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        s_sp_byte_acc ##1 $stable(i_sp_select) |->
        (o_system_stack_pointer_reg - $past(o_system_stack_pointer_reg)
         == (($past(i_mode) == spu_pkg::SPU_MODE_PREDEC)
             ? -ADDR_W'(sp_byte_step) : ADDR_W'(sp_byte_step))))
        else $error("stack pointer byte step wrong");

    a_predec_addr: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_access && i_mode == spu_pkg::SPU_MODE_PREDEC) |=>
        o_mem_addr == $past(cur_val) - ADDR_W'($past(step)))
        else $error("predecrement address wrong");

    a_postinc_addr: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_access && i_mode == spu_pkg::SPU_MODE_POSTINC) |=>
        o_mem_addr == $past(cur_val))
        else $error("postincrement address wrong");

    a_valid_follow: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        i_access |=> o_mem_valid)
        else $error("memory valid missing");

    // a write to seven with master selected lands only in the master bank
    a_sp_select: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_write && i_write_num == `SPU_SP_INDEX && !i_access
         && i_sp_select == spu_pkg::SPU_SEL_MASTER) |=>
        (o_master_stack_pointer == $past(i_write_data)
         && $stable(o_user_stack_pointer)
         && $stable(o_interrupt_stack_pointer)))
        else $error("active stack pointer wrong");

    a_down_top: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_access && i_mode == spu_pkg::SPU_MODE_PREDEC && !i_write
         && !i_stack_access && i_reg_num != `SPU_SP_INDEX) |=>
        areg_reg[$past(i_reg_num)] == o_mem_addr)
        else $error("push left register off top item");

    a_up_free: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_access && i_mode == spu_pkg::SPU_MODE_POSTINC && !i_write
         && !i_stack_access && i_reg_num != `SPU_SP_INDEX) |=>
        areg_reg[$past(i_reg_num)] == o_mem_addr + ADDR_W'($past(step)))
        else $error("push left register off next free slot");

    a_long_step: assert property (
        @(posedge i_clk_sys) disable iff (!i_reset_n)
        i_size == spu_pkg::SPU_SZ_LONG |-> step == `SPU_SIZE_LONG)
        else $error("long step wrong");
endmodule // spu_stack_pointer_update
`default_nettype wire

// *** testbench/spu_operand_path_model.sv ***
// model of the memory operand path that consumes operand addresses
`timescale 1ns/1ps
`default_nettype none
module spu_operand_path_model
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset_n,
    input  wire logic        i_mem_valid,
    input  wire logic [31:0] i_mem_addr,
    output logic      [31:0] o_last_addr,
    output logic      [15:0] o_n_seen
);
    // one pulse is one access; a held valid counts once per cycle it stays high
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_last_addr <= 32'h0;
            o_n_seen    <= 16'h0;
        end
        else if (i_mem_valid)
        begin
            o_last_addr <= i_mem_addr;
            o_n_seen    <= o_n_seen + 16'h1;
        end
    end
endmodule // spu_operand_path_model
`default_nettype wire

// *** testbench/spu_stack_pointer_update_tb.sv ***
// self-checking bench for the stack pointer update block
`timescale 1ns/1ps
`default_nettype none
module spu_stack_pointer_update_tb;
    logic               i_clk_sys = 1'b0;
    logic               i_reset_n = 1'b0;
    spu_pkg::spu_sel_e  sel       = spu_pkg::SPU_SEL_USER;
    spu_pkg::spu_mode_e mode      = spu_pkg::SPU_MODE_PLAIN;
    spu_pkg::spu_size_e size      = spu_pkg::SPU_SZ_BYTE;
    logic               access    = 1'b0;
    logic               stk       = 1'b0;
    logic [2:0]         reg_num   = 3'h0;
    logic               wr        = 1'b0;
    logic [2:0]         wr_num    = 3'h0;
    logic [31:0]        wr_data   = 32'h0;
    logic [2:0]         rd_num    = 3'h0;
    logic [31:0]        rd_data, mem_addr, ssp, user_stack_pointer, interrupt_stack_pointer, master_stack_pointer, last_addr;
    logic               mem_valid;
    logic [15:0]        n_seen;
    int                 fails = 0, n_compared = 0, n_req = 0;
    always #10 i_clk_sys = ~i_clk_sys;
////////////////////////////////////////////////////////////////////////////
    spu_stack_pointer_update spu_stack_pointer_update_i (.i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n), .i_sp_select(sel), .i_access(access),
        .i_stack_access(stk), .i_reg_num(reg_num), .i_mode(mode),
        .i_size(size), .i_write(wr), .i_write_num(wr_num),
        .i_write_data(wr_data), .i_read_num(rd_num), .o_read_data(rd_data),
        .o_mem_addr(mem_addr), .o_mem_valid(mem_valid),
        .o_system_stack_pointer_reg(ssp), .o_user_stack_pointer(user_stack_pointer),
        .o_interrupt_stack_pointer(interrupt_stack_pointer), .o_master_stack_pointer(master_stack_pointer));
    spu_operand_path_model spu_operand_path_model_i (.i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n), .i_mem_valid(mem_valid),
        .i_mem_addr(mem_addr), .o_last_addr(last_addr), .o_n_seen(n_seen));
////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, g);
    begin
        n_compared++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    end
    endtask
    task automatic wreg(input logic [2:0] r, input logic [31:0] d);
    begin
        @(posedge i_clk_sys);
        wr <= 1'b1; wr_num <= r; wr_data <= d;
        @(posedge i_clk_sys);
        wr <= 1'b0;
    end
    endtask
    task automatic rreg(input logic [2:0] r, input logic [31:0] e);
    begin
        @(posedge i_clk_sys);
        rd_num <= r;
        #1;
        chk("read_data", e, rd_data);
    end
    endtask
    // request taken at the edge after setup; answer checked 1 ns after that same edge
    task automatic req(input logic [2:0] r, input spu_pkg::spu_mode_e m,
        input spu_pkg::spu_size_e s, input logic st, input logic [31:0] ea);
    begin
        @(posedge i_clk_sys);
        reg_num <= r; mode <= m; size <= s; stk <= st; access <= 1'b1;
        @(posedge i_clk_sys);
        access <= 1'b0; stk <= 1'b0;
        n_req++;
        #1;
        chk("mem_valid", 32'h1, {31'h0, mem_valid});
        chk("mem_addr", ea, mem_addr);
    end
    endtask
////////////////////////////////////////////////////////////////////////////
    task automatic s_reset;
    begin
        chk("user_sp", 32'h0, user_stack_pointer);
        chk("intr_sp", 32'h0, interrupt_stack_pointer);
        chk("mstr_sp", 32'h0, master_stack_pointer);
        chk("mem_valid", 32'h0, {31'h0, mem_valid});
    end
    endtask
    task automatic s_down_stack;
    begin
        wreg(3'h3, 32'h100);
        req(3'h3, spu_pkg::SPU_MODE_PREDEC, spu_pkg::SPU_SZ_LONG,
            1'b0, 32'hfc);
        rreg(3'h3, 32'hfc);
        req(3'h3, spu_pkg::SPU_MODE_POSTINC, spu_pkg::SPU_SZ_WORD,
            1'b0, 32'hfc);
        rreg(3'h3, 32'hfe);
        // plain indirect uses the register and leaves it alone
        req(3'h3, spu_pkg::SPU_MODE_PLAIN, spu_pkg::SPU_SZ_LONG,
            1'b0, 32'hfe);
        rreg(3'h3, 32'hfe);
        req(3'h2, spu_pkg::SPU_MODE_POSTINC, spu_pkg::SPU_SZ_BYTE,
            1'b0, 32'h0);
        rreg(3'h2, 32'h1);
    end
    endtask
    task automatic s_up_stack;
    begin
        wreg(3'h5, 32'h40);
        req(3'h5, spu_pkg::SPU_MODE_POSTINC, spu_pkg::SPU_SZ_LONG,
            1'b0, 32'h40);
        rreg(3'h5, 32'h44);
        req(3'h5, spu_pkg::SPU_MODE_PREDEC, spu_pkg::SPU_SZ_LONG,
            1'b0, 32'h40);
        rreg(3'h5, 32'h40);
    end
    endtask
    // implicit stack access names register 2 but must go through seven
    task automatic s_byte_stack;
    begin
        @(posedge i_clk_sys);
        sel <= spu_pkg::SPU_SEL_INTERRUPT;
        wreg(3'h7, 32'h200);
        req(3'h2, spu_pkg::SPU_MODE_PREDEC, spu_pkg::SPU_SZ_BYTE,
            1'b1, 32'h1fe);
        chk("intr_sp", 32'h1fe, interrupt_stack_pointer);
        chk("user_sp", 32'h0, user_stack_pointer);
        req(3'h7, spu_pkg::SPU_MODE_POSTINC, spu_pkg::SPU_SZ_BYTE,
            1'b0, 32'h1fe);
        chk("system_sp", 32'h200, ssp);
    end
    endtask
    task automatic s_select;
        spu_pkg::spu_sel_e k;
    begin
        k = spu_pkg::SPU_SEL_USER;
        for (int i = 0; i < 3; i++)
        begin
            @(posedge i_clk_sys);
            sel <= k;
            wreg(3'h7, 32'h1000 + 32'(i));
            rreg(3'h7, 32'h1000 + 32'(i));
            k = k.next();
        end
        chk("user_sp", 32'h1000, user_stack_pointer);
        chk("intr_sp", 32'h1001, interrupt_stack_pointer);
        chk("mstr_sp", 32'h1002, master_stack_pointer);
    end
    endtask
////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
    begin
        $display("compared %0d fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    initial
    begin
        repeat (5) @(posedge i_clk_sys);
        s_reset();
        i_reset_n <= 1'b1;
        s_down_stack();
        s_up_stack();
        s_byte_stack();
        s_select();
        @(posedge i_clk_sys);
        chk("pulse_count", 32'(n_req), {16'h0, n_seen});
        chk("last_addr", 32'h1fe, last_addr);
        wrap_up();
    end
    // the tests need well under 200 cycles
    initial
    begin
        #20000;
        fails++;
        wrap_up();
    end
endmodule // spu_stack_pointer_update_tb
`default_nettype wire
